// ===== design/bst_pkg.sv
package bst_pkg;

    // Shape of the scan path and of the boundary chain.
    localparam int IR_LEN   = 16;
    localparam int ID_LEN   = 32;
    localparam int NPIN     = 8;
    localparam int BSR_LEN  = 3 * NPIN;
    localparam int LEN_W    = 6;

    // Instruction opcodes.
    localparam logic [15:0] OP_BYPASS0  = 16'h0000;
    localparam logic [15:0] OP_BYPASS1  = 16'hFFFF;
    localparam logic [15:0] OP_SAMPLE   = 16'hFFF8;
    localparam logic [15:0] OP_EXTEST   = 16'hFFE8;
    localparam logic [15:0] OP_CLAMP    = 16'hFFEF;
    localparam logic [15:0] OP_IDCODE   = 16'hFFFE;
    localparam logic [15:0] OP_HIGHZ    = 16'hFFCF;
    localparam logic [15:0] OP_PRIVATE_INTERNAL_REGISTER_SELECT = 16'hFFFD;

    // Capture and reset values.
    localparam logic [15:0] IR_CAPTURE  = 16'h0001;
    localparam logic [15:0] IR_RESET    = OP_IDCODE;
    localparam logic [31:0] PRIV_RESET  = 32'h0000_0000;

    // Lengths of each data register, in bits.
    localparam logic [5:0] LEN_BYP   = 6'h01;
    localparam logic [5:0] LEN_BSR   = 6'h18;
    localparam logic [5:0] LEN_ID    = 6'h20;
    localparam logic [5:0] LEN_PRIV  = 6'h20;

    // Bit positions of the three cells of one pin inside the chain.
    localparam int CELL_IN   = 0;
    localparam int CELL_OUT  = 1;
    localparam int CELL_OE   = 2;

    // Controller states, Gray coded along the usual path.
    typedef enum logic [3:0] {
        ST_TLR    = 4'h0,
        ST_RTI    = 4'h1,
        ST_SEL_DR = 4'h3,
        ST_CAP_DR = 4'h2,
        ST_SH_DR  = 4'h6,
        ST_EX1_DR = 4'h7,
        ST_PA_DR  = 4'h5,
        ST_EX2_DR = 4'h4,
        ST_UPD_DR = 4'hC,
        ST_SEL_IR = 4'hD,
        ST_CAP_IR = 4'hF,
        ST_SH_IR  = 4'hE,
        ST_EX1_IR = 4'hA,
        ST_PA_IR  = 4'hB,
        ST_EX2_IR = 4'h9,
        ST_UPD_IR = 4'h8
    } bst_state_t;

    // Data register chosen by the current instruction.
    typedef enum logic [1:0] {
        DR_BYP  = 2'h0,
        DR_BSR  = 2'h1,
        DR_ID   = 2'h2,
        DR_PRIV = 2'h3
    } bst_dr_t;

    // The serial test pins as they arrive from the tester.
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } bst_link_t;

endpackage : bst_pkg

// ===== design/bst_tap.sv
`timescale 1ns/1ps
// Overview of operation
// - Standard test port: controller, instruction, data registers.
// - Serial traffic timed only by the test clock.
// - Mode select and data sampled on rising edge.
// - Data out changes on test clock falling edge.
// - Port works only while test mode asserted.
// - Sixteen-bit instruction decodes the listed opcodes.
// - Identification opcode selects 32-bit fixed code.
// - Every digital pin has a chain cell.
module bst_tap
    import bst_pkg::*;
#(
    parameter logic [31:0] ID_VALUE = 32'h0A5A_5001  // Arbitrary identification value, LSB must be one.
) (
    // System clock and reset.
    input  wire logic              clk_sys,
    input  wire logic              reset_n,
    // Test port from the tester.
    input  wire bst_link_t         link_in,
    input  wire logic              test_mode,
    output logic                   tdo,
    output logic                   tdo_oe,
    // Core side of the digital pins.
    input  wire logic [NPIN-1:0]   core_out,
    input  wire logic [NPIN-1:0]   core_oe,
    output logic [NPIN-1:0]        core_in,
    // Pad side of the digital pins.
    input  wire logic [NPIN-1:0]   pad_in,
    output logic [NPIN-1:0]        pad_out,
    output logic [NPIN-1:0]        pad_oe,
    // Private internal register contents.
    output logic [31:0]            priv_value
);

    // Register chosen by an instruction; anything unlisted falls to bypass.
    function automatic bst_dr_t decode_dr(input logic [15:0] op);
        case (op)
            OP_SAMPLE, OP_EXTEST:                decode_dr = DR_BSR;
            OP_IDCODE:                           decode_dr = DR_ID;
            OP_PRIVATE_INTERNAL_REGISTER_SELECT: decode_dr = DR_PRIV;
            default:                             decode_dr = DR_BYP;
        endcase
    endfunction : decode_dr

    // Length of the selected register.
    function automatic logic [LEN_W-1:0] dr_len(input bst_dr_t sel);
        case (sel)
            DR_BSR:  dr_len = LEN_BSR;
            DR_ID:   dr_len = LEN_ID;
            DR_PRIV: dr_len = LEN_PRIV;
            default: dr_len = LEN_BYP;
        endcase
    endfunction : dr_len

    // Controller transition for one rising test clock edge.
    function automatic bst_state_t tap_next(input bst_state_t s, input logic m);
        case (s)
            ST_TLR:    tap_next = m ? ST_TLR    : ST_RTI;
            ST_RTI:    tap_next = m ? ST_SEL_DR : ST_RTI;
            ST_SEL_DR: tap_next = m ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: tap_next = m ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR:  tap_next = m ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: tap_next = m ? ST_UPD_DR : ST_PA_DR;
            ST_PA_DR:  tap_next = m ? ST_EX2_DR : ST_PA_DR;
            ST_EX2_DR: tap_next = m ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: tap_next = m ? ST_SEL_DR : ST_RTI;
            ST_SEL_IR: tap_next = m ? ST_TLR    : ST_CAP_IR;
            ST_CAP_IR: tap_next = m ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR:  tap_next = m ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: tap_next = m ? ST_UPD_IR : ST_PA_IR;
            ST_PA_IR:  tap_next = m ? ST_EX2_IR : ST_PA_IR;
            ST_EX2_IR: tap_next = m ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: tap_next = m ? ST_SEL_DR : ST_RTI;
            default:   tap_next = ST_TLR;
        endcase
    endfunction : tap_next

    // Two flip-flops on every input from outside; the first stage feeds only the second.
    logic [3:0]        sync1;
    logic [3:0]        sync2;
    logic [NPIN-1:0]   pin1;
    logic [NPIN-1:0]   pin2;
    logic              tck_d;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sync1 <= 4'h0;
            sync2 <= 4'h0;
            pin1  <= '0;
            pin2  <= '0;
            tck_d <= 1'b0;
        end else begin
            sync1 <= {test_mode, link_in.tck, link_in.tms, link_in.tdi};
            sync2 <= sync1;
            pin1  <= pad_in;
            pin2  <= pin1;
            tck_d <= sync2[2];
        end
    end

    logic test_en;
    logic tck_s;
    logic tms_s;
    logic tdi_s;
    logic tck_rise;
    logic tck_fall;

    // Edges of the test clock as seen by the system clock; nothing else paces the port.
    assign test_en  = sync2[3];
    assign tck_s    = sync2[2];
    assign tms_s    = sync2[1];
    assign tdi_s    = sync2[0];
    assign tck_rise = tck_s & ~tck_d;
    assign tck_fall = ~tck_s & tck_d;
    assign core_in  = pin2;

    bst_state_t             state;
    bst_state_t             next_state;
    logic [IR_LEN-1:0]      ir;
    logic [IR_LEN-1:0]      next_ir;
    logic [IR_LEN-1:0]      ir_sh;
    logic [IR_LEN-1:0]      next_ir_sh;
    logic [31:0]            dr_sh;
    logic [31:0]            next_dr_sh;
    logic [BSR_LEN-1:0]     bsr_upd;
    logic [BSR_LEN-1:0]     next_bsr_upd;
    logic [31:0]            priv;
    logic [31:0]            next_priv;
    logic                   next_tdo;
    logic                   next_tdo_oe;
    logic [NPIN-1:0]        next_pad_out;
    logic [NPIN-1:0]        next_pad_oe;
    bst_dr_t                dr_sel;
    logic                   drive_mode;
    logic                   float_mode;
    logic [LEN_W-1:0]       len;

    assign dr_sel     = decode_dr(ir);
    assign len        = dr_len(dr_sel);
    assign drive_mode = test_en && (ir == OP_EXTEST || ir == OP_CLAMP);
    assign float_mode = test_en && (ir == OP_HIGHZ);
    assign priv_value = priv;

    // Next values of the controller, the scan registers and the pads.
    always_comb begin
        next_state   = state;
        next_ir      = ir;
        next_ir_sh   = ir_sh;
        next_dr_sh   = dr_sh;
        next_bsr_upd = bsr_upd;
        next_priv    = priv;
        next_tdo     = tdo;
        next_tdo_oe  = tdo_oe;
        if (!test_en) begin
            // Pins belong to their normal functions; hold the port in reset.
            next_state  = ST_TLR;
            next_ir     = IR_RESET;
            next_tdo_oe = 1'b0;
        end else begin
            if (state == ST_TLR) begin
                next_ir = IR_RESET;
            end
            if (tck_rise) begin
                next_state = tap_next(state, tms_s);
                case (state)
                    ST_CAP_IR: next_ir_sh = IR_CAPTURE;
                    ST_SH_IR:  next_ir_sh = {tdi_s, ir_sh[IR_LEN-1:1]};
                    ST_UPD_IR: next_ir    = ir_sh;
                    ST_CAP_DR: begin
                        case (dr_sel)
                            DR_BSR: begin
                                next_dr_sh = '0;
                                for (int i = 0; i < NPIN; i++) begin
                                    next_dr_sh[3*i+CELL_IN]  = pin2[i];
                                    next_dr_sh[3*i+CELL_OUT] = core_out[i];
                                    next_dr_sh[3*i+CELL_OE]  = core_oe[i];
                                end
                            end
                            DR_ID:   next_dr_sh = ID_VALUE;
                            DR_PRIV: next_dr_sh = priv;
                            default: next_dr_sh = '0;
                        endcase
                    end
                    ST_SH_DR: begin
                        // The bit at the selected length takes data in; bits above stay clear.
                        for (int i = 0; i < 32; i++) begin
                            if (i == int'(len) - 1) begin
                                next_dr_sh[i] = tdi_s;
                            end else if (i < int'(len) - 1) begin
                                next_dr_sh[i] = dr_sh[i+1];
                            end else begin
                                next_dr_sh[i] = 1'b0;
                            end
                        end
                    end
                    ST_UPD_DR: begin
                        if (dr_sel == DR_BSR) begin
                            next_bsr_upd = dr_sh[BSR_LEN-1:0];
                        end else if (dr_sel == DR_PRIV) begin
                            next_priv = dr_sh;
                        end
                    end
                    default: begin
                    end
                endcase
            end
            if (tck_fall) begin
                // Output follows the falling edge so the tester reads it on the next rise.
                next_tdo    = (state == ST_SH_IR) ? ir_sh[0] : dr_sh[0];
                next_tdo_oe = (state == ST_SH_IR) || (state == ST_SH_DR);
            end
        end
        // Pads take chain values in drive modes and float in the high impedance mode.
        for (int i = 0; i < NPIN; i++) begin
            next_pad_out[i] = drive_mode ? bsr_upd[3*i+CELL_OUT] : core_out[i];
            next_pad_oe[i]  = float_mode ? 1'b0 :
                              drive_mode ? bsr_upd[3*i+CELL_OE] : core_oe[i];
        end
    end

    // Register the group.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state   <= ST_TLR;
            ir      <= IR_RESET;
            ir_sh   <= '0;
            dr_sh   <= '0;
            bsr_upd <= '0;
            priv    <= PRIV_RESET;
            tdo     <= 1'b0;
            tdo_oe  <= 1'b0;
            pad_out <= '0;
            pad_oe  <= '0;
        end else begin
            state   <= next_state;
            ir      <= next_ir;
            ir_sh   <= next_ir_sh;
            dr_sh   <= next_dr_sh;
            bsr_upd <= next_bsr_upd;
            priv    <= next_priv;
            tdo     <= next_tdo;
            tdo_oe  <= next_tdo_oe;
            pad_out <= next_pad_out;
            pad_oe  <= next_pad_oe;
        end
    end

    // Checks on the port behaviour.
    tdo_edge_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (test_en && !tck_fall) |=> $stable(tdo) && $stable(tdo_oe))
        else $error("Data out changed away from a falling test clock edge.");
    shift_drive_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (test_en && tck_fall && state == ST_SH_DR) |=> tdo_oe && tdo == $past(dr_sh[0]))
        else $error("Data out not driven with chain bit during shift.");
    mode_gate_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !test_en |=> state == ST_TLR && !tdo_oe)
        else $error("Port active while test mode is low.");
    state_hold_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (test_en && !tck_rise) |=> state == $past(state))
        else $error("Controller moved without a rising test clock edge.");
    tms_step_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (test_en && tck_rise && state == ST_RTI && tms_s) |=> state == ST_SEL_DR)
        else $error("Mode select high did not leave idle.");
    tlr_exit_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (test_en && tck_rise && state == ST_TLR && !tms_s) |=> state == ST_RTI ##1 ir == IR_RESET)
        else $error("Reset state exit or instruction reset wrong.");
    ir_decode_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (ir == OP_EXTEST || ir == OP_SAMPLE) |-> dr_sel == DR_BSR)
        else $error("Boundary instruction did not select the chain.");
    id_capture_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (test_en && tck_rise && state == ST_CAP_DR && dr_sel == DR_ID) |=> dr_sh == ID_VALUE)
        else $error("Identification value not captured.");
    ext_drive_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (test_en && ir == OP_EXTEST) ##1 (ir == OP_EXTEST) |-> pad_out[0] == $past(bsr_upd[CELL_OUT]))
        else $error("Pad not driven from the chain under extest.");
    unknown_byp_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (ir != OP_EXTEST && ir != OP_SAMPLE && ir != OP_IDCODE &&
         ir != OP_PRIVATE_INTERNAL_REGISTER_SELECT) |-> dr_sel == DR_BYP && len == LEN_BYP)
        else $error("Unlisted opcode did not select bypass.");

endmodule : bst_tap

// ===== tb/bst_tester.sv
`timescale 1ns/1ps
module bst_tester
    import bst_pkg::*;
(
    // Serial link towards the device.
    output bst_link_t   link,
    input  wire logic   tdo
);
    logic last_tdi;

    // The clock stands low between frames, so no stray edge reaches the device.
    initial begin
        link     = '0;
        last_tdi = 1'b0;
    end

    // One period: data set at the fall, held 40 ns either side of the rise, output read twice while high.
    // Calls start on a system clock edge, so the pins move by non-blocking assignment to avoid a sampling race.
    task automatic step(input logic tms, input logic tdi, output logic early, output logic late);
        link.tck <= 1'b0;
        link.tms <= tms;
        link.tdi <= tdi;
        last_tdi = tdi;
        #40;
        link.tck <= 1'b1;
        #5;
        early = tdo;
        #33;
        late = tdo;
        #2;
    endtask : step

    // Ends a frame; the data line shows the inverse of its last bit so no stale value looks valid.
    // It then waits long enough for the closing fall and any new instruction to reach the outputs.
    task automatic idle();
        link.tck <= 1'b0;
        link.tdi <= ~last_tdi;
        #40;
    endtask : idle
endmodule : bst_tester

// ===== tb/bst_tap_bench.sv
`timescale 1ns/1ps
module bst_tap_bench;
    import bst_pkg::*;
    localparam logic [31:0] ID_EXP = 32'h1234_5671;  // Arbitrary identification value.
    logic            clk_sys, reset_n, test_mode, tdo, tdo_oe;
    bst_link_t       link;
    logic [NPIN-1:0] core_out, core_oe, core_in, pad_in, pad_out, pad_oe;
    logic [31:0]     priv_value;
    logic [63:0]     dout;
    logic [15:0]     cap;
    int              failures, checks;

    bst_tap #(.ID_VALUE(ID_EXP)) i_bst_tap (.clk_sys(clk_sys), .reset_n(reset_n), .link_in(link),
        .test_mode(test_mode), .tdo(tdo), .tdo_oe(tdo_oe), .core_out(core_out), .core_oe(core_oe),
        .core_in(core_in), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .priv_value(priv_value));
    bst_tester i_bst_tester (.link(link), .tdo(tdo));

    // The system clock at 100 MHz.
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Reports one compared value.
    task automatic check_vec(input logic [63:0] got, input logic [63:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check_vec

    task automatic stop_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test

    // One test clock; the output must not move while the clock is high.
    task automatic tick(input logic tms, input logic tdi, output logic b);
        logic late;
        i_bst_tester.step(tms, tdi, b, late);
        check_vec(late, b, "tdo moved during high phase");
    endtask : tick

    // Walks the controller with a tms sequence, lowest bit first.
    task automatic walk(input logic [7:0] seq, input int n);
        logic b;
        for (int i = 0; i < n; i++) begin
            tick(seq[i], 1'b0, b);
        end
    endtask : walk

    // Shifts n bits lowest first and leaves on the last one.
    task automatic shift(input int n, input logic [63:0] din, output logic [63:0] d);
        logic b;
        d = '0;
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], b);
            d[i] = b;
            if (i == 0) check_vec(tdo_oe, 1, "tdo_oe in shift");
        end
    endtask : shift

    task automatic load_ir(input logic [15:0] op, output logic [15:0] c);
        logic [63:0] d;
        walk(8'h03, 4);
        shift(IR_LEN, op, d);
        walk(8'h01, 2);
        i_bst_tester.idle();
        c = d[15:0];
        check_vec(tdo_oe, 0, "tdo_oe idle");
    endtask : load_ir

    task automatic scan_dr(input int n, input logic [63:0] din, output logic [63:0] d);
        walk(8'h01, 3);
        shift(n, din, d);
        walk(8'h01, 2);
        i_bst_tester.idle();
    endtask : scan_dr

    // After reset the identification register answers without any instruction load.
    task automatic sc_idcode();
        walk(8'h1F, 6);
        scan_dr(32, '0, dout);
        check_vec(dout, ID_EXP, "id value");
        load_ir(OP_BYPASS1, cap);
        check_vec(cap, IR_CAPTURE, "ir capture");
    endtask : sc_idcode

    // Preload through sample, then extest puts the chain on the pads.
    task automatic sc_boundary();
        logic [63:0] p, m, e;
        p = '0;
        m = '0;
        e = '0;
        for (int i = 0; i < NPIN; i++) begin
            p[3*i+1] = i[0];
            p[3*i+2] = i[1];
            m[3*i]   = 1'b1;
            e[3*i]   = ~i[2] ^ i[0];
        end
        pad_in <= 8'hA5;
        load_ir(OP_SAMPLE, cap);
        check_vec(core_in, 8'hA5, "core_in");
        scan_dr(BSR_LEN, p, dout);
        check_vec(dout & m, e, "captured pads");
        load_ir(OP_EXTEST, cap);
        check_vec(pad_out, 8'hAA, "extest pad_out");
        check_vec(pad_oe, 8'hCC, "extest pad_oe");
    endtask : sc_boundary

    // Bypass-class opcodes give a one-bit path; clamp and highz also act on the pads.
    task automatic sc_bypass();
        logic [15:0] ops [5] = '{OP_BYPASS0, OP_BYPASS1, OP_CLAMP, OP_HIGHZ, 16'h1234};
        // Core enables all high, so the high impedance check can really fail.
        core_oe <= 8'hFF;
        foreach (ops[k]) begin
            load_ir(ops[k], cap);
            scan_dr(8, 8'hB5, dout);
            check_vec(dout, 8'h6A, "bypass path");
            if (ops[k] == OP_BYPASS0) check_vec(pad_oe, 8'hFF, "bypass pad_oe");
            if (ops[k] == OP_CLAMP) check_vec(pad_out, 8'hAA, "clamp pad_out");
            if (ops[k] == OP_CLAMP) check_vec(pad_oe, 8'hCC, "clamp pad_oe");
            if (ops[k] == OP_HIGHZ) check_vec(pad_oe, 8'h00, "highz pad_oe");
        end
    endtask : sc_bypass

    task automatic sc_private();
        load_ir(OP_PRIVATE_INTERNAL_REGISTER_SELECT, cap);
        scan_dr(32, 32'hC3A5_0F96, dout);
        check_vec(dout, PRIV_RESET, "private reset value");
        check_vec(priv_value, 32'hC3A5_0F96, "private update");
        scan_dr(32, '0, dout);
        check_vec(dout, 32'hC3A5_0F96, "private readback");
    endtask : sc_private

    // With test mode low the port ignores traffic and the pads follow the core.
    task automatic sc_test_mode();
        logic b;
        test_mode <= 1'b0;
        core_out  <= 8'h3C;
        core_oe   <= 8'hC3;
        repeat (4) @(posedge clk_sys);
        for (int i = 0; i < 12; i++) begin
            tick(i < 2, 1'b1, b);
            check_vec(tdo_oe, 0, "port active without test mode");
        end
        i_bst_tester.idle();
        check_vec(pad_out, 8'h3C, "pad_out follows core");
        check_vec(pad_oe, 8'hC3, "pad_oe follows core");
        test_mode <= 1'b1;
        repeat (4) @(posedge clk_sys);
        walk(8'h1F, 6);
        scan_dr(32, '0, dout);
        check_vec(dout, ID_EXP, "id after test mode");
    endtask : sc_test_mode

    // A hung run is cut short and counted.
    initial begin
        #200_000;
        failures++;
        stop_test();
    end

    initial begin
        failures  = 0;
        checks    = 0;
        reset_n   = 1'b0;
        test_mode = 1'b1;
        core_out  = 8'h00;
        core_oe   = 8'h00;
        pad_in    = 8'h00;
        repeat (5) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (5) @(posedge clk_sys);
        sc_idcode();
        sc_boundary();
        sc_bypass();
        sc_private();
        sc_test_mode();
        stop_test();
    end
endmodule : bst_tap_bench
